// *** core/isme_pkg.sv ***
// constants and types shared by the i2c slave mode engine
`default_nettype none

package isme_pkg;

	// register offsets, byte addresses on the wishbone slave
	localparam logic [7:0] ADR_CONTROL   = 8'h00;
	localparam logic [7:0] ADR_OWN_ADDR  = 8'h04;
	localparam logic [7:0] ADR_DATA_CMD  = 8'h08;
	localparam logic [7:0] ADR_MASK      = 8'h0C;
	localparam logic [7:0] ADR_MASKED    = 8'h10;
	localparam logic [7:0] ADR_RAW       = 8'h14;
	localparam logic [7:0] ADR_CLR_RDREQ = 8'h18;
	localparam logic [7:0] ADR_CLR_ABORT = 8'h1C;
	localparam logic [7:0] ADR_CLR_OVER  = 8'h20;
	localparam logic [7:0] ADR_ENABLE    = 8'h24;
	localparam logic [7:0] ADR_STATUS    = 8'h28;

	// control_word fields
	localparam int CON_MASTER_BIT = 0;
	localparam int CON_TEN_BIT    = 3;
	localparam int CON_SLVOFF_BIT = 6;
	localparam int CON_W          = 7;
	localparam logic [6:0] CONTROL_RESET = 7'h00;

	// own_slave_address, value is arbitrary
	localparam int SAR_W = 10;
	localparam logic [9:0] SAR_RESET = 10'h055;
	localparam logic [4:0] TEN_PREFIX = 5'h1E;

	// raw and masked status fields
	localparam int RAW_RX_OVER = 1;
	localparam int RAW_RX_FULL = 2;
	localparam int RAW_RD_REQ  = 5;
	localparam int RAW_ABORT   = 6;
	localparam int RAW_W       = 7;
	localparam logic [6:0] MASK_RESET = 7'h00;

	// status register fields
	localparam int ST_ACTIVE = 0;
	localparam int ST_TFNF   = 1;
	localparam int ST_TFE    = 2;
	localparam int ST_RX_NOT_EMPTY = 3;

	// data command and enable fields
	localparam int DCMD_CMD_BIT = 8;
	localparam int ENABLE_BIT   = 0;

	// fifo geometry and bit counting
	localparam int BYTE_W   = 8;
	localparam int TX_DEPTH = 8;
	localparam int RX_DEPTH = 8;
	localparam logic [3:0] BITS_LAST = 4'h7;
	localparam logic [3:0] BITS_FULL = 4'h8;

	// wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} isme_wb_req_type;

	// open drain drive of the two bus lines
	typedef struct packed {
		logic scl_out;
		logic scl_oe;
		logic sda_out;
		logic sda_oe;
	} isme_pin_drive_type;

	// bus side states, gray along the usual path
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_ADDR  = 4'h1,
		ST_ACK   = 4'h3,
		ST_LOAD  = 4'h2,
		ST_TX    = 4'h6,
		ST_TXACK = 4'h7,
		ST_RX    = 4'h5,
		ST_RXACK = 4'h4,
		ST_ADDR2 = 4'hC
	} isme_state_type;

endpackage

`default_nettype wire

// *** core/isme_fifo.sv ***
// byte fifo with flush, used for transmit and receive
`timescale 1ns/1ps
`default_nettype none

module isme_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             arst_n_i,
	input  wire logic             flush_i,
	// fill side
	input  wire logic             wr_valid_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	output logic                  wr_ready_o,
	// drain side
	output logic                  rd_valid_o,
	input  wire logic             rd_ready_i,
	output logic [WIDTH-1:0]      rd_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wp_reg;
	logic [AW-1:0]    rp_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	// handshakes and head of queue
	assign wr_ready_o = (cnt_reg != (AW+1)'(DEPTH));
	assign rd_valid_o = (cnt_reg != '0);
	assign rd_data_o  = mem_reg[rp_reg];
	assign push       = wr_valid_i & wr_ready_o & ~flush_i;
	assign pop        = rd_valid_o & rd_ready_i & ~flush_i;

	// storage, no reset needed
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem_reg[wp_reg] <= wr_data_i;
		end
	end

	// pointers and fill count, flush empties at once
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else if (flush_i) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wp_reg <= wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= rp_reg + 1'b1;
			end
			if (push && !pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end

endmodule // isme_fifo

`default_nettype wire

// *** core/isme_slave.sv ***
// slave mode engine of a two-wire serial bus controller
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module isme_slave (
	// clock and reset
	input  wire logic                        clock_i,
	input  wire logic                        arst_n_i,
	// wishbone slave
	input  wire isme_pkg::isme_wb_req_type   wb_req_i,
	output logic [31:0]                      wb_dat_o,
	output logic                             wb_ack_o,
	// serial bus lines
	input  wire logic                        scl_in_i,
	input  wire logic                        sda_in_i,
	output isme_pkg::isme_pin_drive_type     pin_o
);
	import isme_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [2:0]          scl_sync_reg;
	logic [2:0]          sda_sync_reg;
	logic                scl_rise, scl_fall, bus_start, bus_stop;
	logic                req, ack_reg, wr_do, rd_do;
	logic [31:0]         rd_mux, dat_reg;
	logic [CON_W-1:0]    ctrl_reg;
	logic [SAR_W-1:0]    sar_reg;
	logic [RAW_W-1:0]    mask_reg, raw;
	logic                enable_reg, rd_req_reg, abort_reg, over_reg;
	logic                tx_push, tx_ready, tx_valid, tx_pop, tx_flush;
	logic                rx_push, rx_ready, rx_valid, rx_pop;
	logic [BYTE_W-1:0]   tx_data, rx_data;
	isme_state_type      state_reg, go_reg;
	logic [BYTE_W-1:0]   sh_reg;
	logic [3:0]          cnt_reg;
	logic                sda_oe_reg, scl_oe_reg, ack_seen_reg, ten_hit_reg;
	logic                rdreq_set_reg, abort_set_reg, flush_reg;
	logic                live, can_send, seven_hit, ten_hi_hit;

	////////////////////////////////////////////////////////////////////////
	// two flops before any logic, third for edge finding
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in_i};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in_i};
		end
	end

	// line events from the synchronised copies
	assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
	assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
	assign bus_start = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[1] & sda_sync_reg[2];
	assign bus_stop  = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[1] & ~sda_sync_reg[2];

	////////////////////////////////////////////////////////////////////////
	// one wait state: data captured on first edge, taken on ack edge
	assign req      = wb_req_i.cyc & wb_req_i.stb;
	assign wr_do    = req & ack_reg & wb_req_i.we;
	assign rd_do    = req & ack_reg & ~wb_req_i.we;
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	// raw flags, receive-full follows the fifo
	always_comb begin
		raw              = '0;
		raw[RAW_RX_OVER] = over_reg;
		raw[RAW_RX_FULL] = rx_valid;
		raw[RAW_RD_REQ]  = rd_req_reg;
		raw[RAW_ABORT]   = abort_reg;
	end

	// read data mux, unmapped reads as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (wb_req_i.adr)
			ADR_CONTROL:  rd_mux[CON_W-1:0] = ctrl_reg;
			ADR_OWN_ADDR: rd_mux[SAR_W-1:0] = sar_reg;
			ADR_DATA_CMD: rd_mux[BYTE_W-1:0] = rx_data;
			ADR_MASK:     rd_mux[RAW_W-1:0] = mask_reg;
			ADR_MASKED:   rd_mux[RAW_W-1:0] = raw & mask_reg;
			ADR_RAW:      rd_mux[RAW_W-1:0] = raw;
			ADR_ENABLE:   rd_mux[ENABLE_BIT] = enable_reg;
			ADR_STATUS: begin
				rd_mux[ST_ACTIVE] = (state_reg != ST_IDLE);
				rd_mux[ST_TFNF]   = tx_ready;
				rd_mux[ST_TFE]    = ~tx_valid;
				rd_mux[ST_RX_NOT_EMPTY] = rx_valid;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dat_reg <= 32'h0000_0000;
		end else if (req && !ack_reg) begin
			dat_reg <= rd_mux;
		end
	end

	// configuration, untouched by the enable bit
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_reg   <= CONTROL_RESET;
			sar_reg    <= SAR_RESET;
			mask_reg   <= MASK_RESET;
			enable_reg <= 1'b0;
		end else if (wr_do) begin
			if (wb_req_i.adr == ADR_CONTROL && wb_req_i.sel[0]) begin
				ctrl_reg <= wb_req_i.dat[CON_W-1:0];
			end
			if (wb_req_i.adr == ADR_OWN_ADDR) begin
				if (wb_req_i.sel[0]) begin
					sar_reg[BYTE_W-1:0] <= wb_req_i.dat[BYTE_W-1:0];
				end
				if (wb_req_i.sel[1]) begin
					sar_reg[SAR_W-1:BYTE_W] <= wb_req_i.dat[SAR_W-1:BYTE_W];
				end
			end
			if (wb_req_i.adr == ADR_MASK && wb_req_i.sel[0]) begin
				mask_reg <= wb_req_i.dat[RAW_W-1:0];
			end
			if (wb_req_i.adr == ADR_ENABLE && wb_req_i.sel[0]) begin
				enable_reg <= wb_req_i.dat[ENABLE_BIT];
			end
		end
	end

	// sticky flags, a set in the clearing cycle wins
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_req_reg <= 1'b0;
			abort_reg  <= 1'b0;
			over_reg   <= 1'b0;
		end else begin
			rd_req_reg <= rdreq_set_reg | (rd_req_reg & ~(rd_do &
				((wb_req_i.adr == ADR_CLR_RDREQ) | ((wb_req_i.adr == ADR_RAW) &
				~mask_reg[RAW_RD_REQ] & dat_reg[RAW_RD_REQ]))));
			abort_reg <= abort_set_reg | (abort_reg & ~(rd_do &
				((wb_req_i.adr == ADR_CLR_ABORT) | ((wb_req_i.adr == ADR_RAW) &
				~mask_reg[RAW_ABORT] & dat_reg[RAW_ABORT]))));
			over_reg <= (rx_push & ~rx_ready) |
				(over_reg & ~(rd_do & (wb_req_i.adr == ADR_CLR_OVER)));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fifos: transmit writes blocked and transmit content held flushed while abort stands
	assign tx_push  = wr_do & (wb_req_i.adr == ADR_DATA_CMD) & wb_req_i.sel[0] &
		~(wb_req_i.sel[1] & wb_req_i.dat[DCMD_CMD_BIT]) & enable_reg & ~abort_reg;
	assign tx_flush = ~enable_reg | abort_reg | flush_reg;
	assign rx_pop   = rd_do & (wb_req_i.adr == ADR_DATA_CMD);

	isme_fifo #(.WIDTH(BYTE_W), .DEPTH(TX_DEPTH)) tx_fifo (
		.clock_i    (clock_i),
		.arst_n_i   (arst_n_i),
		.flush_i    (tx_flush),
		.wr_valid_i (tx_push),
		.wr_data_i  (wb_req_i.dat[BYTE_W-1:0]),
		.wr_ready_o (tx_ready),
		.rd_valid_o (tx_valid),
		.rd_ready_i (tx_pop),
		.rd_data_o  (tx_data)
	);

	isme_fifo #(.WIDTH(BYTE_W), .DEPTH(RX_DEPTH)) rx_fifo (
		.clock_i    (clock_i),
		.arst_n_i   (arst_n_i),
		.flush_i    (~enable_reg),
		.wr_valid_i (rx_push),
		.wr_data_i  (sh_reg),
		.wr_ready_o (rx_ready),
		.rd_valid_o (rx_valid),
		.rd_ready_i (rx_pop),
		.rd_data_o  (rx_data)
	);

	////////////////////////////////////////////////////////////////////////
	// address compare and send gating
	assign live       = enable_reg & ~ctrl_reg[CON_SLVOFF_BIT] & ~ctrl_reg[CON_MASTER_BIT];
	assign seven_hit  = (sh_reg[7:1] == sar_reg[6:0]);
	assign ten_hi_hit = (sh_reg[7:3] == TEN_PREFIX) & (sh_reg[2:1] == sar_reg[SAR_W-1:BYTE_W]);
	// pending set pulses also block, so a stale byte never leaves before its flush
	assign can_send   = tx_valid & ~rd_req_reg & ~abort_reg & ~rdreq_set_reg & ~flush_reg;
	assign tx_pop     = (state_reg == ST_LOAD) & can_send & live;
	assign rx_push    = (state_reg == ST_RX) & scl_fall & (cnt_reg == BITS_FULL) & live;

	// bus side machine: bits move on the synchronised scl edges
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg     <= ST_IDLE;
			go_reg        <= ST_IDLE;
			sh_reg        <= '0;
			cnt_reg       <= '0;
			sda_oe_reg    <= 1'b0;
			ack_seen_reg  <= 1'b0;
			ten_hit_reg   <= 1'b0;
			rdreq_set_reg <= 1'b0;
			abort_set_reg <= 1'b0;
			flush_reg     <= 1'b0;
		end else begin
			rdreq_set_reg <= 1'b0;
			abort_set_reg <= 1'b0;
			flush_reg     <= 1'b0;
			if (!live || bus_stop) begin
				state_reg   <= ST_IDLE;
				sda_oe_reg  <= 1'b0;
				ten_hit_reg <= 1'b0;
			end else if (bus_start) begin
				state_reg  <= ST_ADDR;
				cnt_reg    <= '0;
				sda_oe_reg <= 1'b0;
			end else begin
				unique case (state_reg)
					ST_IDLE: begin
						sda_oe_reg <= 1'b0;
					end
					ST_ADDR, ST_ADDR2, ST_RX: begin
						if (scl_rise) begin
							sh_reg  <= {sh_reg[6:0], sda_sync_reg[1]};
							cnt_reg <= cnt_reg + 1'b1;
						end else if (scl_fall && cnt_reg == BITS_FULL) begin
							sda_oe_reg <= 1'b1;
							state_reg  <= ST_ACK;
							go_reg     <= ST_RX;
							if (state_reg == ST_ADDR2) begin
								if (sh_reg == sar_reg[BYTE_W-1:0]) begin
									ten_hit_reg <= 1'b1;
								end else begin
									sda_oe_reg <= 1'b0;
									state_reg  <= ST_IDLE;
								end
							end else if (state_reg == ST_ADDR) begin
								if (!ctrl_reg[CON_TEN_BIT]) begin
									if (!seven_hit) begin
										sda_oe_reg <= 1'b0;
										state_reg  <= ST_IDLE;
									end
									go_reg <= sh_reg[0] ? ST_LOAD : ST_RX;
								end else if (ten_hi_hit && !sh_reg[0]) begin
									go_reg <= ST_ADDR2;
								end else if (ten_hi_hit && ten_hit_reg) begin
									go_reg <= ST_LOAD;
								end else begin
									sda_oe_reg <= 1'b0;
									state_reg  <= ST_IDLE;
								end
							end
						end
					end
					ST_ACK, ST_RXACK: begin
						if (scl_fall) begin
							sda_oe_reg <= 1'b0;
							cnt_reg    <= '0;
							state_reg  <= (state_reg == ST_RXACK) ? ST_RX : go_reg;
							if (state_reg == ST_ACK && go_reg == ST_LOAD) begin
								rdreq_set_reg <= 1'b1;
								abort_set_reg <= tx_valid;
								flush_reg     <= tx_valid;
							end
						end
					end
					ST_LOAD: begin
						if (can_send) begin
							sh_reg     <= tx_data;
							sda_oe_reg <= ~tx_data[7];
							cnt_reg    <= '0;
							state_reg  <= ST_TX;
						end
					end
					ST_TX: begin
						if (scl_fall) begin
							if (cnt_reg == BITS_LAST) begin
								sda_oe_reg <= 1'b0;
								state_reg  <= ST_TXACK;
							end else begin
								sh_reg     <= {sh_reg[6:0], 1'b0};
								sda_oe_reg <= ~sh_reg[6];
								cnt_reg    <= cnt_reg + 1'b1;
							end
						end
					end
					ST_TXACK: begin
						if (scl_rise) begin
							ack_seen_reg <= ~sda_sync_reg[1];
						end else if (scl_fall) begin
							if (ack_seen_reg) begin
								state_reg     <= ST_LOAD;
								rdreq_set_reg <= ~tx_valid;
							end else begin
								state_reg     <= ST_IDLE;
								flush_reg     <= tx_valid;
								abort_set_reg <= tx_valid;
							end
						end
					end
					default: begin
						state_reg  <= ST_IDLE;
						sda_oe_reg <= 1'b0;
					end
				endcase
				if (state_reg == ST_RX && scl_fall && cnt_reg == BITS_FULL) begin
					state_reg <= ST_RXACK;
				end
			end
		end
	end

	// clock stretch while waiting for transmit data
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scl_oe_reg <= 1'b0;
		end else begin
			scl_oe_reg <= live & (state_reg == ST_LOAD) & ~can_send;
		end
	end

	// open drain pins only ever pull low
	assign pin_o = '{scl_out: 1'b0, scl_oe: scl_oe_reg, sda_out: 1'b0, sda_oe: sda_oe_reg};

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	wb_ack_pulse_a: assert property (req && !ack_reg |=> ack_reg ##1 !ack_reg)
		else $error("wishbone ack not a single pulse");
	stretch_wait_a: assert property (live && state_reg == ST_LOAD && rd_req_reg |=> pin_o.scl_oe)
		else $error("clock not stretched while read request stands");
	abort_raise_a: assert property (state_reg == ST_ACK && go_reg == ST_LOAD && scl_fall && tx_valid && live
		&& !bus_stop && !bus_start |=> ##1 abort_reg && !tx_valid)
		else $error("stale data not aborted");
	abort_hold_a: assert property (abort_reg && $past(abort_reg) |-> !tx_valid)
		else $error("transmit fifo not held flushed");
	send_release_a: assert property (state_reg == ST_TX |=> !pin_o.scl_oe)
		else $error("clock still stretched during send");
	rx_full_a: assert property (rx_push && rx_ready |=> raw[RAW_RX_FULL] && !rx_ready || rx_valid)
		else $error("receive data not flagged");
	overflow_flag_a: assert property (rx_push && !rx_ready |=> over_reg)
		else $error("overflow not flagged");
	rereq_raise_a: assert property (state_reg == ST_TXACK && scl_fall && ack_seen_reg && !tx_valid && live
		&& !bus_stop && !bus_start |=> ##1 rd_req_reg)
		else $error("read request not raised again");
	nack_release_a: assert property (state_reg == ST_TXACK && scl_fall && !ack_seen_reg && live
		&& !bus_start |=> !pin_o.sda_oe && state_reg == ST_IDLE)
		else $error("data line not released on nack");

endmodule // isme_slave

`default_nettype wire

// *** test/isme_master_model.sv ***
// remote bus master model on the two open drain lines
`timescale 1ns/1ps
`default_nettype none

module isme_master_model (
	// clock and resolved lines
	input  wire logic clock_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	// pulls, high drags the line low
	output logic      scl_oe_o,
	output logic      sda_oe_o
);
	// bus idles released, clock stands still between frames
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// wait n system clocks
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// one bit: data set in low phase, clock released, stretch honoured
	task automatic bit_cycle(input logic b, output logic got);
		tick(2);
		sda_oe_o <= ~b;
		tick(2);
		scl_oe_o <= 1'b0;
		tick(1);
		while (scl_i !== 1'b1)
			tick(1);
		tick(2);
		got = sda_i;
		tick(2);
		scl_oe_o <= 1'b1;
	endtask

	// start or repeated start, slow enough to let a slave ack end
	task automatic start();
		sda_oe_o <= 1'b0;
		tick(4);
		scl_oe_o <= 1'b0;
		tick(4);
		sda_oe_o <= 1'b1;
		tick(4);
		scl_oe_o <= 1'b1;
	endtask

	// stop, data rises while clock high
	task automatic stop();
		sda_oe_o <= 1'b1;
		tick(4);
		scl_oe_o <= 1'b0;
		tick(4);
		sda_oe_o <= 1'b0;
		tick(4);
	endtask

	// eight bits msb first and the acknowledge bit
	task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx, output logic ack_seen);
		for (int i = 7; i >= 0; i--)
			bit_cycle(tx[i], rx[i]);
		bit_cycle(ack_bit, ack_seen);
	endtask
endmodule // isme_master_model

`default_nettype wire

// *** test/isme_slave_tb.sv ***
// self-checking bench of the slave mode engine
`timescale 1ns/1ps
`default_nettype none

module isme_slave_tb;
	import isme_pkg::*;
	logic               clock_i;
	logic               arst_n_i;
	isme_wb_req_type    req;
	logic [31:0]        wb_dat;
	logic               wb_ack;
	isme_pin_drive_type pin;
	logic               m_scl_oe;
	logic               m_sda_oe;
	logic               scl_line;
	logic               sda_line;
	logic [31:0]        q;
	logic [7:0]         rx;
	logic [7:0]         dat [RX_DEPTH+1];
	logic [9:0]         sa;
	logic               ak;
	logic               ak2;
	int                 seed;
	int                 n_errors;
	int                 total_checks;

	// wired-and of both parties, pulled up
	assign scl_line = ~(m_scl_oe | pin.scl_oe);
	assign sda_line = ~(m_sda_oe | pin.sda_oe);

	isme_slave dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .wb_req_i(req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
		.scl_in_i(scl_line), .sda_in_i(sda_line), .pin_o(pin));
	isme_master_model mdl (.clock_i(clock_i), .scl_i(scl_line), .sda_i(sda_line), .scl_oe_o(m_scl_oe),
		.sda_oe_o(m_sda_oe));

	// 20 mhz clock
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	////////////////////////////////////////////////////////////////
	// address byte the remote master sends first
	function automatic logic [7:0] head(input logic [9:0] a, input logic ten, input logic rw);
		return ten ? {TEN_PREFIX, a[9:8], rw} : {a[6:0], rw};
	endfunction

	// compare and count
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one classic wishbone cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] r);
		int t;
		t = 0;
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h3, dat: d};
		@(posedge clock_i);
		while (wb_ack !== 1'b1 && t < 50) begin
			@(posedge clock_i);
			t++;
		end
		if (t == 50)
			check("wb ack", 32'h1, 32'h0);
		r = wb_dat;
		req <= '0;
		@(posedge clock_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		wb(1'b0, a, 32'h0, r);
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	// verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// watchdog against a hung bus
	initial begin
		#2_000_000;
		check("watchdog", 32'h0, 32'h1);
		results();
	end

	// main sequence
	initial begin
		seed = 86031;
		n_errors = 0;
		total_checks = 0;
		req = '0;
		arst_n_i = 1'b0;
		repeat (3) @(posedge clock_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		rd(ADR_CONTROL, q);
		check("control", {25'h0, CONTROL_RESET}, q);
		rd(ADR_OWN_ADDR, q);
		check("own address", {22'h0, SAR_RESET}, q);
		rd(8'h30, q);
		check("unmapped", 32'h0, q);
		sa = 10'h008 + 10'($random(seed) & 63);
		wr(ADR_ENABLE, 32'h0);
		wr(ADR_OWN_ADDR, {22'h0, sa});
		wr(ADR_CONTROL, 32'h0);
		wr(ADR_ENABLE, 32'h1);
		wr(ADR_ENABLE, 32'h0);
		wr(ADR_ENABLE, 32'h1);
		rd(ADR_OWN_ADDR, q);
		check("address kept", {22'h0, sa}, q);
		done("config");
		// receive one byte beyond the fifo depth
		mdl.start();
		mdl.xfer(head(sa, 1'b0, 1'b0), 1'b1, rx, ak);
		check("address ack", 32'h0, 32'(ak));
		for (int i = 0; i <= RX_DEPTH; i++) begin
			dat[i] = 8'($random(seed));
			mdl.xfer(dat[i], 1'b1, rx, ak);
			check("data ack", 32'h0, 32'(ak));
		end
		mdl.stop();
		rd(ADR_RAW, q);
		check("raw rx full", 32'h1, 32'(q[RAW_RX_FULL]));
		check("raw overflow", 32'h1, 32'(q[RAW_RX_OVER]));
		rd(ADR_STATUS, q);
		check("rx not empty", 32'h1, 32'(q[ST_RX_NOT_EMPTY]));
		for (int i = 0; i < RX_DEPTH; i++) begin
			rd(ADR_DATA_CMD, q);
			check("rx byte", {24'h0, dat[i]}, q);
		end
		rd(ADR_STATUS, q);
		check("rx drained", 32'h0, 32'(q[ST_RX_NOT_EMPTY]));
		rd(ADR_CLR_OVER, q);
		mdl.start();
		mdl.xfer(head(sa ^ 10'h001, 1'b0, 1'b0), 1'b1, rx, ak);
		check("foreign nack", 32'h1, 32'(ak));
		mdl.stop();
		done("receive");
		// transmit with stale data, refills and an early end
		wr(ADR_DATA_CMD, 32'hA5);
		mdl.start();
		mdl.xfer(head(sa, 1'b0, 1'b1), 1'b1, rx, ak);
		check("read address ack", 32'h0, 32'(ak));
		mdl.tick(10);
		check("stretch", 32'h1, 32'(pin.scl_oe));
		rd(ADR_STATUS, q);
		check("stale flushed", 32'h1, 32'(q[ST_TFE]));
		wr(ADR_DATA_CMD, 32'h5A);
		rd(ADR_STATUS, q);
		check("held flushed", 32'h1, 32'(q[ST_TFE]));
		rd(ADR_RAW, q);
		check("request and abort", 32'h3, 32'(q[RAW_ABORT:RAW_RD_REQ]));
		rd(ADR_RAW, q);
		check("cleared on read", 32'h0, 32'(q[RAW_ABORT:RAW_RD_REQ]));
		rd(ADR_CLR_ABORT, q);
		for (int i = 0; i < 5; i++) begin
			dat[i] = 8'($random(seed));
			if (i < 3)
				wr(ADR_DATA_CMD, {24'h0, dat[i]});
		end
		for (int i = 0; i < 3; i++) begin
			mdl.xfer(8'hFF, 1'b0, rx, ak);
			check("tx byte", {24'h0, dat[i]}, {24'h0, rx});
			mdl.tick(8);
			rd(ADR_RAW, q);
			check("request only when empty", 32'(i == 2), 32'(q[RAW_RD_REQ]));
		end
		check("stretch again", 32'h1, 32'(pin.scl_oe));
		wr(ADR_DATA_CMD, {24'h0, dat[3]});
		wr(ADR_DATA_CMD, {24'h0, dat[4]});
		mdl.xfer(8'hFF, 1'b1, rx, ak);
		check("last byte", {24'h0, dat[3]}, {24'h0, rx});
		mdl.tick(6);
		check("data released", 32'h0, 32'(pin.sda_oe));
		mdl.stop();
		rd(ADR_STATUS, q);
		check("leftover dropped", 32'h1, 32'(q[ST_TFE]));
		wr(ADR_MASK, 32'h40);
		rd(ADR_RAW, q);
		rd(ADR_MASKED, q);
		check("masked abort kept", 32'h1, 32'(q[RAW_ABORT]));
		rd(ADR_CLR_ABORT, q);
		rd(ADR_RAW, q);
		check("abort cleared", 32'h0, 32'(q[RAW_ABORT]));
		wr(ADR_MASK, 32'h0);
		done("transmit");
		// slave switched off ignores its own address
		wr(ADR_ENABLE, 32'h0);
		wr(ADR_CONTROL, 32'h40);
		wr(ADR_ENABLE, 32'h1);
		mdl.start();
		mdl.xfer(head(sa, 1'b0, 1'b0), 1'b1, rx, ak);
		check("slave off nack", 32'h1, 32'(ak));
		mdl.stop();
		done("slave off");
		// ten-bit address recognition
		sa = 10'($random(seed));
		wr(ADR_ENABLE, 32'h0);
		wr(ADR_OWN_ADDR, {22'h0, sa});
		wr(ADR_CONTROL, 32'h8);
		wr(ADR_ENABLE, 32'h1);
		dat[0] = 8'($random(seed));
		mdl.start();
		mdl.xfer(head(sa, 1'b1, 1'b0), 1'b1, rx, ak);
		mdl.xfer(sa[7:0], 1'b1, rx, ak2);
		check("ten-bit ack", 32'h0, 32'({ak, ak2}));
		mdl.xfer(dat[0], 1'b1, rx, ak);
		mdl.stop();
		rd(ADR_DATA_CMD, q);
		check("ten-bit byte", {24'h0, dat[0]}, q);
		done("ten-bit");
		results();
	end
endmodule // isme_slave_tb

`default_nettype wire
